//--- logic/cfl_loader.sv
// configuration frame loader: peripheral byte port, serialiser,
// frame checker, daisy-chain forwarding and start-up sequencing
// assumes one 20 MHz core clock; all pins arrive asynchronously
//
// Functional notes
// [R1] stream starts with a 40-bit preamble, then a set number of frames
// [R2] each frame ends in three one stop bits, then a zero start bit
// [R3] after a frame, the first zero bit opens the next frame
// [R4] a frame is accepted only when its last three bits are ones
// [R5] bad stop bits drive init low and halt loading; config_clock keeps running
// [R6] outside party restarts after an error with reset low over 6 us
// [R7] option picks internal reset release one config_clock before or after outputs
// [R8] internal reset holds user flops at zero throughout configuration
// [R9] optional divide-by-two between oscillator and alternate clock line
// [R10] reset pin passes a two-stage shifter so short high spikes vanish
// [R11] outputs of the whole chain switch on at one config_clock edge
// [R12] outputs start slew limited, then follow their own slew bits
// [R13] byte taken on trailing edge of chip selects and write strobe
// [R14] byte goes into a double buffer, then shifts out serially
// [R15] preamble and overflow data leave on the serial chain output
// [R16] ready drops on a byte, rises once the buffer is free again
// [R17] busy lasts two config_clock periods when the shifter was empty
// [R18] busy lasts up to nine config_clock periods when the shifter was full
// [R19] last byte shifts seven bits; config_clock stays high, dout holds bit 6
// [R20] system may hold reset low until all chained inits are high
// [R21] processor writes the next byte only once ready is high

module cfl_loader
  import cfl_pkg::*;
#(
  parameter int FRAME_BITS = 75,  // bits after the start bit, stops included
  parameter int NUM_FRAMES = 16,  // frames this device keeps
  parameter int FRAME_W    = 16,  // width of frame counters
  parameter int LEN_W      = 24,  // width of stream bit count
  parameter int N_OUT      = 8,   // user outputs under slew control
  parameter int SOFT_CONFIG_CLOCK  = 4    // config_clock periods of soft start-up
) (
  input  wire logic             core_clk_i,     // core clock, 20 MHz
  input  wire logic             reset_n_i,      // sync reset, active low
  input  wire logic             rst_pin_n_i,    // chip reset pin, active low
  input  wire cfl_pins_t        pins_i,         // selects, strobe, data byte
  input  wire logic             osc_i,          // crystal oscillator pin
  input  wire logic             osc_div2_i,     // 1: halve oscillator
  input  wire logic             reset_early_i,  // 1: reset before outputs
  input  wire logic [N_OUT-1:0] slew_fast_i,    // per-output fast slew bit
  input  wire logic [LEN_W-1:0] stream_bits_i,  // bits in whole stream
  output logic                  config_clock_o, // configuration clock
  output logic                  dout_o,         // serial chain output
  output logic                  rdy_busy_o,     // 1 ready, 0 busy
  output logic                  init_n_o,       // init status, active low
  output logic                  cfg_bit_o,      // bit into config memory
  output logic                  cfg_bit_vld_o,  // one-cycle bit strobe
  output logic                  user_reset_o,   // internal user reset
  output logic                  outputs_en_o,   // user outputs active
  output logic      [N_OUT-1:0] slew_limit_o,   // 1: output slew limited
  output logic                  alt_clock_o     // alternate clock line
);

  localparam int PIN_W  = $bits(cfl_pins_t);
  localparam int SYNC_W = PIN_W + 2;

  typedef struct packed {
    cfl_state_t         state;
    logic [DIV_W-1:0]   div_cnt;
    logic               phase;
    logic               config_clock;
    logic               rf1;
    logic               rf2;
    logic               rst_filt;
    logic               sel_d;
    logic               osc_d;
    logic               alt;
    logic [7:0]         hold;
    logic               hold_full;
    logic               hold_aged;
    logic [7:0]         sr;
    logic [SR_CNT_W-1:0] sr_cnt;
    logic               rdy;
    logic [LEN_W-1:0]   sent;
    logic               ended;
    logic [FRAME_W-1:0] cnt;
    logic [FRAME_W-1:0] frames;
    logic [2:0]         hist;
    logic               dout;
    logic               cfg_bit;
    logic               cfg_vld;
    logic               init_n;
    logic               user_rst;
    logic               out_en;
    logic [DIV_W-1:0]   soft_cnt;
    logic               soft_done;
    logic [N_OUT-1:0]   slew;
  } cfl_loader_st_t;

  cfl_loader_st_t    s_ff;
  cfl_loader_st_t    nxt_s;
  logic [SYNC_W-1:0] sync_q;
  cfl_pins_t         pin_s;
  logic              osc_s;
  logic              rst_s;
  logic              sel;
  logic              cap;
  logic              tick;
  logic              bit_vld;
  logic              bit_val;
  logic [2:0]        hist_nxt;

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  cfl_pin_sync #(
    .W (SYNC_W)
  ) u_sync (
    .core_clk_i (core_clk_i),
    .reset_n_i  (reset_n_i),
    .d_i        ({rst_pin_n_i, osc_i, pins_i}),
    .q_o        (sync_q)
  );

  // unpack the filtered pin levels
  assign pin_s = cfl_pins_t'(sync_q[PIN_W-1:0]);
  assign osc_s = sync_q[PIN_W];
  assign rst_s = sync_q[PIN_W+1];
  assign sel   = pin_s.cs_a & pin_s.cs_b & pin_s.cs_c & pin_s.ws;
  assign cap   = s_ff.sel_d & ~sel;  // see [R13]

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    nxt_s         = s_ff;
    tick          = 1'b0;
    bit_vld       = 1'b0;
    bit_val       = s_ff.sr[0];
    hist_nxt      = {s_ff.hist[1:0], s_ff.sr[0]};
    nxt_s.cfg_vld = 1'b0;

    // config_clock divider; tick marks each rising config_clock edge
    if (s_ff.div_cnt == DIV_W'(CONFIG_CLOCK_HALF_CYC - 1)) begin
      nxt_s.div_cnt = '0;
      nxt_s.phase   = ~s_ff.phase;
      tick          = ~s_ff.phase;
    end else begin
      nxt_s.div_cnt = s_ff.div_cnt + 1'b1;
    end
    // parked high once the stream is through, but never in error
    nxt_s.config_clock = nxt_s.phase | (s_ff.ended &&
                 s_ff.state inside {ST_FWD, ST_START, ST_USER});  // see [R19] [R5]

    // slow two-stage reset shifter; a sub-period spike fills one stage
    if (tick) begin
      nxt_s.rf1 = rst_s;                                 // see [R10]
      nxt_s.rf2 = s_ff.rf1;
      if (s_ff.rf1 == s_ff.rf2) begin
        nxt_s.rst_filt = s_ff.rf1;
      end
    end

    // serialiser: reload only when empty and the byte has aged a tick
    if (tick && s_ff.state != ST_CLEAR) begin
      if (s_ff.hold_full) begin
        nxt_s.hold_aged = 1'b1;                          // see [R17]
      end
      if (s_ff.sr_cnt == '0) begin
        if (s_ff.hold_full && s_ff.hold_aged) begin
          nxt_s.sr        = s_ff.hold;                   // see [R14]
          nxt_s.sr_cnt    = SR_CNT_W'(BYTE_BITS);
          nxt_s.hold_full = 1'b0;
          nxt_s.rdy       = 1'b1;                        // see [R16] [R18]
        end
      end else if (!s_ff.ended) begin
        bit_vld      = 1'b1;
        nxt_s.sr     = s_ff.sr >> 1;
        nxt_s.sr_cnt = s_ff.sr_cnt - 1'b1;
        nxt_s.sent   = s_ff.sent + 1'b1;
        // a last byte of seven bits leaves bit 7 unshifted
        if ((s_ff.sent + 1'b1) == stream_bits_i) begin
          nxt_s.ended = 1'b1;                            // see [R19]
        end
      end
    end

    // byte capture; a write while the buffer is full is dropped
    if (cap && !s_ff.hold_full && !s_ff.ended &&
        !(s_ff.state inside {ST_CLEAR, ST_ERROR})) begin
      nxt_s.hold      = pin_s.data;                      // see [R13]
      nxt_s.hold_full = 1'b1;
      nxt_s.hold_aged = 1'b0;
      nxt_s.rdy       = 1'b0;                            // see [R16]
    end

    // frame checker on every serial bit
    if (bit_vld) begin
      nxt_s.hist = hist_nxt;
      case (s_ff.state)
        ST_PRE: begin
          nxt_s.dout = bit_val;                          // see [R15]
          if (s_ff.cnt == FRAME_W'(PREAMBLE_BITS - 1)) begin
            nxt_s.cnt   = '0;
            nxt_s.state = ST_GAP;                        // see [R1]
          end else begin
            nxt_s.cnt = s_ff.cnt + 1'b1;
          end
        end
        ST_GAP: begin
          if (bit_val == START_BIT) begin
            nxt_s.state   = ST_FRAME;                    // see [R3] [R2]
            nxt_s.cnt     = '0;
            nxt_s.cfg_vld = 1'b1;
            nxt_s.cfg_bit = bit_val;
          end
        end
        ST_FRAME: begin
          nxt_s.cfg_vld = 1'b1;
          nxt_s.cfg_bit = bit_val;
          if (s_ff.cnt == FRAME_W'(FRAME_BITS - 1)) begin
            nxt_s.cnt = '0;
            if (hist_nxt != STOP_PATTERN) begin
              nxt_s.state = ST_ERROR;                    // see [R4] [R5]
            end else if (s_ff.frames == FRAME_W'(NUM_FRAMES - 1)) begin
              nxt_s.state = ST_FWD;                      // see [R1]
            end else begin
              nxt_s.frames = s_ff.frames + 1'b1;
              nxt_s.state  = ST_GAP;
            end
          end else begin
            nxt_s.cnt = s_ff.cnt + 1'b1;
          end
        end
        ST_FWD: begin
          nxt_s.dout = bit_val;                          // see [R15]
        end
        default: begin
        end
      endcase
    end

    // a stream that runs out before our frames are in is broken
    if (s_ff.ended && s_ff.state inside {ST_PRE, ST_GAP, ST_FRAME}) begin
      nxt_s.state = ST_ERROR;
    end

    // start-up sequence, one step per config_clock edge
    if (tick) begin
      case (s_ff.state)
        ST_CLEAR: begin
          if (s_ff.rst_filt) begin
            nxt_s.state = ST_PRE;
          end
        end
        ST_FWD: begin
          if (s_ff.ended) begin
            nxt_s.state = ST_START;
            if (reset_early_i) begin
              nxt_s.user_rst = 1'b0;                     // see [R7]
            end else begin
              nxt_s.out_en = 1'b1;                       // see [R11]
            end
          end
        end
        ST_START: begin
          nxt_s.out_en   = 1'b1;                         // see [R7] [R11]
          nxt_s.user_rst = 1'b0;
          nxt_s.state    = ST_USER;
        end
        ST_USER: begin
          if (!s_ff.soft_done) begin
            if (s_ff.soft_cnt == DIV_W'(SOFT_CONFIG_CLOCK - 1)) begin
              nxt_s.soft_done = 1'b1;                    // see [R12]
            end else begin
              nxt_s.soft_cnt = s_ff.soft_cnt + 1'b1;
            end
          end
        end
        default: begin
        end
      endcase
    end

    // in user mode the pin acts directly as the user reset
    if (s_ff.state == ST_USER) begin
      nxt_s.user_rst = ~rst_s;
    end

    // a filtered low reset aborts loading and clears the datapath
    if (!s_ff.rst_filt &&
        s_ff.state inside {ST_PRE, ST_GAP, ST_FRAME, ST_FWD, ST_ERROR}) begin
      nxt_s.state     = ST_CLEAR;                        // see [R5]
      nxt_s.hold_full = 1'b0;
      nxt_s.sr_cnt    = '0;
      nxt_s.rdy       = 1'b1;
      nxt_s.sent      = '0;
      nxt_s.ended     = 1'b0;
      nxt_s.cnt       = '0;
      nxt_s.frames    = '0;
      nxt_s.hist      = '0;
    end

    // status outputs, slew soft start and alternate clock
    nxt_s.init_n = !(nxt_s.state inside {ST_CLEAR, ST_ERROR});  // see [R5]
    nxt_s.slew   = s_ff.soft_done ? ~slew_fast_i : '1;   // see [R12]
    nxt_s.osc_d  = osc_s;
    if (osc_div2_i) begin
      if (osc_s && !s_ff.osc_d) begin
        nxt_s.alt = ~s_ff.alt;                           // see [R9]
      end
    end else begin
      nxt_s.alt = osc_s;
    end
    nxt_s.sel_d = sel;
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  // user reset starts asserted so user flops stay cleared while loading
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      s_ff          <= '0;
      s_ff.state    <= ST_CLEAR;
      s_ff.rdy      <= 1'b1;
      s_ff.user_rst <= 1'b1;                             // see [R8]
      s_ff.slew     <= '1;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign config_clock_o = s_ff.config_clock;
  assign dout_o         = s_ff.dout;
  assign rdy_busy_o     = s_ff.rdy;
  assign init_n_o       = s_ff.init_n;
  assign cfg_bit_o      = s_ff.cfg_bit;
  assign cfg_bit_vld_o  = s_ff.cfg_vld;
  assign user_reset_o   = s_ff.user_rst;
  assign outputs_en_o   = s_ff.out_en;
  assign slew_limit_o   = s_ff.slew;
  assign alt_clock_o    = s_ff.alt;

  // ****************************************************************
  // checks
  // ****************************************************************
  localparam int CHK_CONFIG_CLOCK  = 2 * CONFIG_CLOCK_HALF_CYC;
  localparam int CHK_HALF  = CONFIG_CLOCK_HALF_CYC + 1;

  logic [15:0] busy_len;
  logic        empty_cap;

  // busy length and shifter state at capture, for the checks only
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      busy_len  <= '0;
      empty_cap <= 1'b0;
    end else begin
      busy_len <= nxt_s.rdy ? '0 : busy_len + 1'b1;
      if (s_ff.rdy && !nxt_s.rdy) begin
        empty_cap <= (s_ff.sr_cnt == '0);
      end
    end
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);

  chk_busy_short: assert property ( // see [R17]
    (!rdy_busy_o && empty_cap && !s_ff.ended) |->
      busy_len <= 16'(BUSY_EMPTY_CONFIG_CLOCK * CHK_CONFIG_CLOCK))
    else $error("busy too long with empty shifter");

  chk_busy_long: assert property ( // see [R18]
    (!rdy_busy_o && !s_ff.ended) |->
      busy_len <= 16'(BUSY_FULL_CONFIG_CLOCK * CHK_CONFIG_CLOCK))
    else $error("busy longer than nine config_clock periods");

  chk_stop_error: assert property ( // see [R4]
    (bit_vld && s_ff.state == ST_FRAME &&
     s_ff.cnt == FRAME_W'(FRAME_BITS - 1) && hist_nxt != STOP_PATTERN)
      |=> !init_n_o && s_ff.state != ST_GAP)
    else $error("bad stop bits not flagged");

  chk_frame_start: assert property ( // see [R3]
    (bit_vld && s_ff.state == ST_GAP && !bit_val && s_ff.rst_filt &&
     !s_ff.ended) |=> s_ff.state == ST_FRAME)
    else $error("zero after frame did not open a frame");

  chk_err_clock: assert property ( // see [R5]
    (s_ff.state == ST_ERROR) |-> ##[1:CHK_HALF] $changed(config_clock_o))
    else $error("config_clock stopped in error");

  chk_err_halt: assert property ( // see [R5]
    (s_ff.state == ST_ERROR && s_ff.rst_filt) |=>
      s_ff.state == ST_ERROR && !cfg_bit_vld_o)
    else $error("loading resumed after error");

  chk_out_edge: assert property ( // see [R11]
    $rose(outputs_en_o) |-> $past(tick))
    else $error("outputs enabled off a config_clock edge");

  chk_rst_late: assert property ( // see [R7]
    ($rose(outputs_en_o) && !reset_early_i) |->
      user_reset_o ##CHK_CONFIG_CLOCK !user_reset_o)
    else $error("late reset release not one config_clock after outputs");

  chk_rst_early: assert property ( // see [R7]
    ($fell(user_reset_o) && !outputs_en_o) |->
      !outputs_en_o ##CHK_CONFIG_CLOCK outputs_en_o)
    else $error("early reset release not one config_clock before outputs");

  chk_soft_start: assert property ( // see [R12]
    $rose(outputs_en_o) |-> &slew_limit_o)
    else $error("outputs not slew limited at first activation");

  chk_slew_follow: assert property ( // see [R12]
    (s_ff.soft_done && $past(s_ff.soft_done) && $stable(slew_fast_i))
      |-> slew_limit_o == ~slew_fast_i)
    else $error("slew does not follow its configuration bit");

  chk_cfg_reset: assert property ( // see [R8]
    (s_ff.state inside {ST_PRE, ST_GAP, ST_FRAME, ST_FWD}) |-> user_reset_o)
    else $error("user reset released during configuration");

  chk_last_hold: assert property ( // see [R19]
    (s_ff.ended && s_ff.state == ST_USER) |->
      config_clock_o && $stable(dout_o))
    else $error("config_clock or dout moved after the last bit");

endmodule

//--- logic/cfl_pin_sync.sv
// three-stage pin synchroniser with agreement filter
// assumes inputs are asynchronous to core_clk_i

module cfl_pin_sync #(
  parameter int W = 1
) (
  input  wire logic         core_clk_i,  // core clock
  input  wire logic         reset_n_i,   // sync reset, active low
  input  wire logic [W-1:0] d_i,         // raw pin levels
  output logic      [W-1:0] q_o          // filtered, synchronised levels
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } cfl_sync_st_t;

  cfl_sync_st_t s_ff;
  cfl_sync_st_t nxt_s;

  // ****************************************************************
  // next state
  // ****************************************************************
  // first stage feeds only the second, never the filter
  always_comb begin
    nxt_s    = s_ff;
    nxt_s.s1 = d_i;
    nxt_s.s2 = s_ff.s1;
    nxt_s.s3 = s_ff.s2;
    for (int i = 0; i < W; i++) begin
      if (s_ff.s2[i] == s_ff.s3[i]) begin
        nxt_s.q[i] = s_ff.s2[i];
      end
    end
  end

  // state register
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign q_o = s_ff.q;

endmodule

//--- logic/cfl_pkg.sv
// shared constants and carriers for the configuration frame loader
// assumes a single 20 MHz core clock drives every user of this package

package cfl_pkg;

  // ****************************************************************
  // clock and timing
  // ****************************************************************
  localparam int CORE_CLK_MHZ     = 20;
  localparam int CORE_CLK_NS      = 1000 / CORE_CLK_MHZ;
  localparam int CONFIG_CLOCK_PERIOD_NS   = 1000;
  // half period in core cycles, rounded down so config_clock is never slower
  localparam int CONFIG_CLOCK_HALF_CYC    = (CONFIG_CLOCK_PERIOD_NS / CORE_CLK_NS) / 2;
  localparam int DIV_W            = 8;
  localparam int RESTART_LOW_NS   = 6000;

  // ****************************************************************
  // bitstream framing
  // ****************************************************************
  localparam int          PREAMBLE_BITS = 40;
  localparam logic [2:0]  STOP_PATTERN  = 3'h7;
  localparam logic        START_BIT     = 1'h0;
  localparam int          BYTE_BITS     = 8;
  localparam int          SR_CNT_W      = 4;
  localparam int          BUSY_EMPTY_CONFIG_CLOCK = 2;
  localparam int          BUSY_FULL_CONFIG_CLOCK  = 9;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [2:0] {
    ST_CLEAR,
    ST_PRE,
    ST_GAP,
    ST_FRAME,
    ST_FWD,
    ST_START,
    ST_USER,
    ST_ERROR
  } cfl_state_t;

  // microprocessor side pins, all taken as active high here
  typedef struct packed {
    logic       cs_a;
    logic       cs_b;
    logic       cs_c;
    logic       ws;
    logic [7:0] data;
  } cfl_pins_t;

endpackage

//--- verif/cfl_host_model.sv
// microprocessor model writing bytes into the loader's peripheral port
// assumes the bench calls write_byte from one process at a time
module cfl_host_model
  import cfl_pkg::*;
(
  input  wire logic core_clk_i,  // core clock
  input  wire logic rdy_busy_i,  // 1 ready, 0 busy
  output cfl_pins_t pins_o       // selects, strobe, data
);
  timeunit 1ns;
  timeprecision 1ns;

  initial pins_o = '0;

  // *****************************************************
  // one byte write; busy returns the cycles rdy was low
  // *****************************************************
  task automatic write_byte(input logic [7:0] b, output int busy);
    int n;
    busy = 0;
    n = 0;
    // a write while busy would be dropped, so wait for ready
    while (rdy_busy_i !== 1'h1 && n < 400) begin
      @(negedge core_clk_i);
      n++;
    end
    pins_o.data = b;
    @(negedge core_clk_i);
    {pins_o.cs_a, pins_o.cs_b, pins_o.cs_c, pins_o.ws} = 4'hF;
    repeat (4) @(negedge core_clk_i);
    pins_o.ws = 1'h0;
    // data held past the sync latency, then no longer valid
    for (n = 0; n < 400; n++) begin
      @(negedge core_clk_i);
      if (n == 6) pins_o.data = ~b;
      if (rdy_busy_i === 1'h0) busy++;
      else if (busy > 0 && n >= 6) break;
    end
    {pins_o.cs_a, pins_o.cs_b, pins_o.cs_c} = 3'h0;
    // let an edge pass before the next write touches the pins
    @(negedge core_clk_i);
  endtask
endmodule

//--- verif/cfl_loader_tb.sv
// self-checking bench for the configuration frame loader
// assumes small frame counts: two frames of six bits each
module cfl_loader_tb
  import cfl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic       clk         = 1'h0;
  logic       reset_n_i   = 1'h0;
  logic       rst_pin_n   = 1'h0;
  logic       osc         = 1'h0;
  logic       osc_div2    = 1'h0;
  logic       early       = 1'h0;
  logic [7:0] slew_fast   = 8'hA5;
  logic       config_clock, dout, rdy, init_n, cfg_bit, cfg_vld, urst, oen, alt;
  logic [7:0] slew_lim;
  cfl_pins_t  pins;
  int         miscompares = 0;
  int         cmp_count   = 0;
  int         cyc         = 0;
  int         ocnt        = 0;
  int         t_oen       = -1;
  int         t_urst      = -1;
  logic       cfg_q[$];

  always #25 clk = ~clk;

  cfl_loader #(.FRAME_BITS(6), .NUM_FRAMES(2)) u_dut (
    .core_clk_i(clk), .reset_n_i(reset_n_i), .rst_pin_n_i(rst_pin_n),
    .pins_i(pins), .osc_i(osc), .osc_div2_i(osc_div2),
    .reset_early_i(early), .slew_fast_i(slew_fast),
    .stream_bits_i(24'h00003F), .config_clock_o(config_clock), .dout_o(dout),
    .rdy_busy_o(rdy), .init_n_o(init_n), .cfg_bit_o(cfg_bit),
    .cfg_bit_vld_o(cfg_vld), .user_reset_o(urst), .outputs_en_o(oen),
    .slew_limit_o(slew_lim), .alt_clock_o(alt));

  cfl_host_model u_host (.core_clk_i(clk), .rdy_busy_i(rdy), .pins_o(pins));

  // *****************************************************
  // monitors, oscillator and hang guard
  // *****************************************************
  always @(negedge clk) begin
    ocnt = (ocnt == 7) ? 0 : ocnt + 1;
    if (ocnt == 0) osc = ~osc;
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cfg_vld === 1'h1) cfg_q.push_back(cfg_bit);
    if (oen === 1'h1 && t_oen < 0) t_oen <= cyc;
    if (urst === 1'h0 && t_urst < 0) t_urst <= cyc;
    if (cyc == 30000) begin
      miscompares++;
      final_report();
    end
  end

  // *****************************************************
  // shared helpers
  // *****************************************************
  task automatic chk(string what, logic [63:0] exp, logic [63:0] got);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic bring_up();
    int n;
    reset_n_i = 1'h0;
    repeat (12) @(negedge clk);
    reset_n_i = 1'h1;
    for (n = 0; n < 200 && init_n !== 1'h1; n++) @(negedge clk);
  endtask

  // preamble, idle ones, two framed records, then chain overflow
  function automatic logic [63:0] good_stream();
    logic [63:0] s;
    s = 64'h0;
    s[39:0] = 40'hC35A0FF00E;
    s[42:40] = 3'h7;
    s[43] = START_BIT;
    s[49:44] = {STOP_PATTERN, 3'h5};
    s[50] = START_BIT;
    s[56:51] = {STOP_PATTERN, 3'h2};
    s[62:57] = 6'h1D;
    s[63] = 1'h1;  // never shifted out
    return s;
  endfunction

  task automatic load(logic [63:0] s, int nb);
    int busy;
    int lim;
    cfg_q.delete();
    t_oen = -1;
    t_urst = -1;
    for (int i = 0; i < nb; i++) begin
      u_host.write_byte(s[8*i +: 8], busy);
      // two config_clock when the shifter was empty, else up to nine
      lim = (i == 0 ? BUSY_EMPTY_CONFIG_CLOCK : BUSY_FULL_CONFIG_CLOCK) * 2 * CONFIG_CLOCK_HALF_CYC + 1;
      chk("busy len", 1, busy > 0 && busy <= lim);
      chk("user reset held", 1, urst);
    end
  endtask

  // *****************************************************
  // scenarios
  // *****************************************************
  task automatic run_good(logic opt);
    logic [63:0] s;
    logic [13:0] got;
    int n;
    s = good_stream();
    early = opt;
    bring_up();
    chk("init up", 1, init_n);
    load(s, 8);
    for (n = 0; n < 400 && oen !== 1'h1; n++) @(negedge clk);
    chk("slew at start", 8'hFF, slew_lim);
    repeat (120) @(negedge clk);
    // cast keeps the inversion to the eight slew bits
    chk("slew after", 8'(~slew_fast), slew_lim);
    chk("outputs on", 1, oen);
    chk("init kept", 1, init_n);
    chk("config_clock parked", 1, config_clock);
    chk("dout last", s[62], dout);
    chk("reset order", 20, opt ? t_oen - t_urst : t_urst - t_oen);
    chk("cfg count", 14, cfg_q.size());
    got = '0;
    for (int i = 0; i < 14 && i < cfg_q.size(); i++) got[i] = cfg_q[i];
    chk("cfg bits", s[56:43], got);
  endtask

  task automatic run_bad();
    logic [63:0] s;
    logic pc;
    int n;
    s = good_stream();
    s[48] = 1'h0;  // broken stop bit in the first frame
    bring_up();
    load(s, 7);
    repeat (200) @(negedge clk);
    chk("init on error", 0, init_n);
    n = 0;
    pc = config_clock;
    repeat (100) begin
      @(negedge clk);
      n += int'(config_clock === 1'h1 && pc === 1'h0);
      pc = config_clock;
    end
    chk("config_clock runs", 1, n >= 4);
    chk("outputs off", 0, oen);
    chk("user reset", 1, urst);
    rst_pin_n = 1'h0;
    repeat (140) @(negedge clk);
    rst_pin_n = 1'h1;
    for (n = 0; n < 200 && init_n !== 1'h1; n++) @(negedge clk);
    chk("restart", 1, init_n);
  endtask

  task automatic chk_alt(logic div);
    int a, o;
    logic pa, po;
    osc_div2 = div;
    repeat (40) @(negedge clk);
    a = 0;
    o = 0;
    pa = alt;
    po = osc;
    repeat (640) begin
      @(posedge clk);
      #5;
      a += int'(alt !== pa);
      o += int'(osc !== po);
      pa = alt;
      po = osc;
    end
    // back onto the falling edge before the next stimulus
    @(negedge clk);
    chk("alt edges", 1, (a - (div ? o / 2 : o)) inside {[-1:1]});
  endtask

  task automatic final_report();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // a short high spike on the pin must not start loading
  initial begin
    bring_up();
    repeat (60) @(negedge clk);
    rst_pin_n = 1'h1;
    repeat (10) @(negedge clk);
    rst_pin_n = 1'h0;
    repeat (100) @(negedge clk);
    chk("init after spike", 0, init_n);
    // pin held low until the chain is ready, then released
    rst_pin_n = 1'h1;
    run_good(1'h0);
    run_good(1'h1);
    chk_alt(1'h0);
    chk_alt(1'h1);
    run_bad();
    final_report();
  end
endmodule
